// [src/readback_pkg.sv]
// Package for the port read-back self-test block: register map, reset values and field types.
// Assumes a single 100 MHz system clock and a byte-wide register port.
package readback_pkg;
  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 4;
  localparam logic [7:0]  UNLOCK_PATTERN = 8'hca;
  localparam logic [7:0]  KEY_RESET     = 8'h00;
  localparam logic [7:0]  PORT_RESET    = 8'hff;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;
  localparam logic [3:0]  ADDR_KEY      = 4'h0;
  localparam logic [3:0]  ADDR_A_DATA   = 4'h1;
  localparam logic [3:0]  ADDR_A_DIR    = 4'h2;
  localparam logic [3:0]  ADDR_B_DATA   = 4'h3;
  localparam logic [3:0]  ADDR_B_DIR    = 4'h4;
  localparam logic [3:0]  ADDR_A_FUNC   = 4'h5;
  localparam logic [3:0]  ADDR_B_FUNC   = 4'h6;
  localparam logic [3:0]  ADDR_A_WAKE   = 4'h7;
  localparam logic [3:0]  ADDR_ADC_SEL  = 4'h8;
  localparam logic [3:0]  ADDR_BITOP    = 4'h9;
  localparam logic [3:0]  ADDR_IRQ_STAT = 4'ha;
  localparam logic [3:0]  ADDR_IRQ_MASK = 4'hb;
  localparam logic [3:0]  ADDR_SLEEP    = 4'hc;
  // Bit operation word: [7] set(1)/clear(0), [6:4] bit index, [3:0] target register address.
  localparam int          BITOP_SET     = 7;
  localparam int          BITOP_IDX_HI  = 6;
  localparam int          BITOP_IDX_LO  = 4;
  localparam int          BITOP_ADR_HI  = 3;
  localparam int          IRQ_WAKE      = 0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] out_val;
    logic [DATA_W-1:0] out_en_b;
  } pin_drive_t;
endpackage

// [src/port_readback_selftest.sv]
// Two eight-bit ports with diagnostic read-back, analogue path control and Port A falling-edge wake-up.
// Assumes pins arrive asynchronously and the converter channel select is a register of this block.
`timescale 1ns/1ps
module port_readback_selftest #(
  parameter int PORT_W = 8
) (
  input  wire logic                           clock_i,
  input  wire logic                           rst_b_i,
  input  wire readback_pkg::reg_req_t         req_i,
  output logic [readback_pkg::DATA_W-1:0]     rdata_o,
  input  wire logic [PORT_W-1:0]              pin_a_i,
  input  wire logic [PORT_W-1:0]              pin_b_i,
  output readback_pkg::pin_drive_t            drive_a_o,
  output readback_pkg::pin_drive_t            drive_b_o,
  output logic [2*PORT_W-1:0]                 analog_input_channels_o,
  output logic                                readback_enable_flag_o,
  output logic                                wake_o,
  output logic                                irq_o
);
  import readback_pkg::*;

  logic [1:0]        rst_sync_ff;
  logic              rst_n;
  logic [PORT_W-1:0] a_s1_ff;
  logic [PORT_W-1:0] a_s2_ff;
  logic [PORT_W-1:0] a_prev_ff;
  logic [PORT_W-1:0] b_s1_ff;
  logic [PORT_W-1:0] b_s2_ff;
  logic [7:0]        key_ff;
  logic [7:0]        a_data_ff;
  logic [7:0]        a_dir_ff;
  logic [7:0]        b_data_ff;
  logic [7:0]        b_dir_ff;
  logic [7:0]        a_func_ff;
  logic [7:0]        b_func_ff;
  logic [7:0]        a_wake_ff;
  logic [7:0]        irq_stat_ff;
  logic [7:0]        irq_mask_ff;
  logic [3:0]        adc_sel_ff;
  logic              sleep_ff;
  logic              wake_ff;
  logic [7:0]        rdata_ff;
  logic [7:0]        nxt_rdata;
  logic [7:0]        rd_view;
  logic [7:0]        bop_old;

  // Reset is released through two flops so its removal is clean against the clock.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) rst_sync_ff <= 2'b00;
    else          rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      a_s1_ff   <= '0;
      a_s2_ff   <= '0;
      a_prev_ff <= '0;
      b_s1_ff   <= '0;
      b_s2_ff   <= '0;
    end else begin
      a_s1_ff   <= pin_a_i;
      a_s2_ff   <= a_s1_ff;
      a_prev_ff <= a_s2_ff;
      b_s1_ff   <= pin_b_i;
      b_s2_ff   <= b_s1_ff;
    end
  end

  wire        readback_on = (key_ff == UNLOCK_PATTERN);
  wire        wr_key   = req_i.wr && (req_i.addr == ADDR_KEY);
  wire        wr_adata = req_i.wr && (req_i.addr == ADDR_A_DATA);
  wire        wr_adir  = req_i.wr && (req_i.addr == ADDR_A_DIR);
  wire        wr_bdata = req_i.wr && (req_i.addr == ADDR_B_DATA);
  wire        wr_bdir  = req_i.wr && (req_i.addr == ADDR_B_DIR);
  wire        wr_afunc = req_i.wr && (req_i.addr == ADDR_A_FUNC);
  wire        wr_bfunc = req_i.wr && (req_i.addr == ADDR_B_FUNC);
  wire        wr_awake = req_i.wr && (req_i.addr == ADDR_A_WAKE);
  wire        wr_adc   = req_i.wr && (req_i.addr == ADDR_ADC_SEL);
  wire        wr_bitop = req_i.wr && (req_i.addr == ADDR_BITOP);
  wire        wr_mask  = req_i.wr && (req_i.addr == ADDR_IRQ_MASK);
  wire        wr_sleep = req_i.wr && (req_i.addr == ADDR_SLEEP);
  wire        rd_stat  = req_i.rd && (req_i.addr == ADDR_IRQ_STAT);

  // Bit operations reuse the normal read path, so a set on a data register writes back the pin view.
  wire [3:0]  bop_addr = req_i.wdata[BITOP_ADR_HI:0];
  wire [2:0]  bop_idx  = req_i.wdata[BITOP_IDX_HI:BITOP_IDX_LO];
  wire        bop_set  = req_i.wdata[BITOP_SET];
  wire [7:0]  bop_mask = 8'h01 << bop_idx;

  // Port reads: a function bit of one marks the pin as analogue, which reads 0 in normal mode.
  wire [7:0]  a_view;
  wire [7:0]  b_view;
  assign a_view = readback_on ? a_s2_ff :
                  (~a_func_ff & ((a_dir_ff & a_s2_ff) | (~a_dir_ff & a_data_ff)));
  assign b_view = readback_on ? b_s2_ff :
                  (~b_func_ff & ((b_dir_ff & b_s2_ff) | (~b_dir_ff & b_data_ff)));

  function automatic logic [7:0] reg_view(input logic [3:0] adr, input logic [7:0] av, input logic [7:0] bv);
    case (adr)
      ADDR_KEY:      reg_view = key_ff;
      ADDR_A_DATA:   reg_view = av;
      ADDR_A_DIR:    reg_view = a_dir_ff;
      ADDR_B_DATA:   reg_view = bv;
      ADDR_B_DIR:    reg_view = b_dir_ff;
      ADDR_A_FUNC:   reg_view = a_func_ff;
      ADDR_B_FUNC:   reg_view = b_func_ff;
      ADDR_A_WAKE:   reg_view = a_wake_ff;
      ADDR_ADC_SEL:  reg_view = {4'h0, adc_sel_ff};
      ADDR_IRQ_STAT: reg_view = irq_stat_ff;
      ADDR_IRQ_MASK: reg_view = irq_mask_ff;
      ADDR_SLEEP:    reg_view = {7'h00, sleep_ff};
      default:       reg_view = ZERO_BYTE;
    endcase
  endfunction

  // The function reads registers that are not its arguments, so it lives in a process that tracks them.
  always_comb begin
    bop_old = reg_view(bop_addr, a_view, b_view);
  end
  wire [7:0]  bop_new = bop_set ? (bop_old | bop_mask) : (bop_old & ~bop_mask);
  wire        bop_hit_adata = wr_bitop && (bop_addr == ADDR_A_DATA);
  wire        bop_hit_adir  = wr_bitop && (bop_addr == ADDR_A_DIR);
  wire        bop_hit_bdata = wr_bitop && (bop_addr == ADDR_B_DATA);
  wire        bop_hit_bdir  = wr_bitop && (bop_addr == ADDR_B_DIR);

  wire [7:0]  a_fall   = a_prev_ff & ~a_s2_ff & a_wake_ff;
  wire        wake_evt = sleep_ff && (a_fall != ZERO_BYTE);
  wire [7:0]  evt_vec  = {7'h00, wake_evt};
  wire [7:0]  nxt_stat = (rd_stat ? ZERO_BYTE : irq_stat_ff) | evt_vec;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      key_ff    <= KEY_RESET;
      a_data_ff <= PORT_RESET;
      a_dir_ff  <= PORT_RESET;
      b_data_ff <= PORT_RESET;
      b_dir_ff  <= PORT_RESET;
      a_func_ff <= ZERO_BYTE;
      b_func_ff <= ZERO_BYTE;
      a_wake_ff <= ZERO_BYTE;
      adc_sel_ff <= '0;
      irq_mask_ff <= ZERO_BYTE;
      irq_stat_ff <= ZERO_BYTE;
      sleep_ff  <= 1'b0;
      wake_ff   <= 1'b0;
      rdata_ff  <= ZERO_BYTE;
    end else begin
      if (wr_key)   key_ff    <= req_i.wdata;
      if (wr_adata) a_data_ff <= req_i.wdata;
      else if (bop_hit_adata) a_data_ff <= bop_new;
      if (wr_adir)  a_dir_ff  <= req_i.wdata;
      else if (bop_hit_adir) a_dir_ff <= bop_new;
      if (wr_bdata) b_data_ff <= req_i.wdata;
      else if (bop_hit_bdata) b_data_ff <= bop_new;
      if (wr_bdir)  b_dir_ff  <= req_i.wdata;
      else if (bop_hit_bdir) b_dir_ff <= bop_new;
      if (wr_afunc) a_func_ff <= req_i.wdata;
      if (wr_bfunc) b_func_ff <= req_i.wdata;
      if (wr_awake) a_wake_ff <= req_i.wdata;
      if (wr_adc)   adc_sel_ff <= req_i.wdata[3:0];
      if (wr_mask)  irq_mask_ff <= req_i.wdata;
      // A wake ends sleep; a wake in the same cycle as a sleep write wins.
      if (wake_evt) sleep_ff <= 1'b0;
      else if (wr_sleep) sleep_ff <= req_i.wdata[0];
      wake_ff   <= wake_evt;
      irq_stat_ff <= nxt_stat;
      rdata_ff  <= nxt_rdata;
    end
  end

  // Read data is latched only for a read, so the port shows zero in every other cycle.
  always_comb begin
    rd_view = reg_view(req_i.addr, a_view, b_view);
  end
  assign nxt_rdata = req_i.rd ? rd_view : ZERO_BYTE;
  assign rdata_o   = rdata_ff;

  // Only digital functions drive; an analogue pin releases its driver.
  assign drive_a_o.out_val  = a_data_ff;
  assign drive_a_o.out_en_b = a_dir_ff | a_func_ff;
  assign drive_b_o.out_val  = b_data_ff;
  assign drive_b_o.out_en_b = b_dir_ff | b_func_ff;

  // The converter channel map is port A bits 0..7 then port B bits 0..7.
  wire [15:0] func_all = {b_func_ff, a_func_ff};
  genvar g;
  generate
    for (g = 0; g < 2*PORT_W; g++) begin : g_chan
      wire chan_sel = (adc_sel_ff == 4'(g));
      assign analog_input_channels_o[g] = chan_sel && (func_all[g] || readback_on);
    end
  endgenerate

  assign readback_enable_flag_o = readback_on;
  assign wake_o = wake_ff;
  assign irq_o  = (irq_stat_ff & irq_mask_ff) != ZERO_BYTE;

  // Flag checks compare against the written byte, so a broken pattern compare cannot hide.
  a_flag_set: assert property (@(posedge clock_i) disable iff (!rst_n)
    (wr_key && req_i.wdata == UNLOCK_PATTERN) |=> readback_enable_flag_o)
    else $error("flag not raised by pattern");
  a_flag_clear: assert property (@(posedge clock_i) disable iff (!rst_n)
    (wr_key && req_i.wdata != UNLOCK_PATTERN) |=> !readback_enable_flag_o)
    else $error("flag not cleared by other key");
  a_flag_hold: assert property (@(posedge clock_i) disable iff (!rst_n)
    !wr_key |=> $stable(readback_enable_flag_o))
    else $error("flag moved without key write");

  // Port reads.
  a_readback_pins: assert property (@(posedge clock_i) disable iff (!rst_n)
    (req_i.rd && req_i.addr == ADDR_A_DATA && readback_on) |=> rdata_o == $past(a_s2_ff))
    else $error("read-back read not pin level");
  a_readback_port_b: assert property (@(posedge clock_i) disable iff (!rst_n)
    (req_i.rd && req_i.addr == ADDR_B_DATA && readback_on) |=> rdata_o == $past(b_s2_ff))
    else $error("read-back read not pin level on b");
  a_latch_read: assert property (@(posedge clock_i) disable iff (!rst_n)
    (req_i.rd && req_i.addr == ADDR_A_DATA && !readback_on && a_func_ff == ZERO_BYTE && a_dir_ff == ZERO_BYTE)
    |=> rdata_o == $past(a_data_ff))
    else $error("output read not latch");
  a_analog_reads_zero: assert property (@(posedge clock_i) disable iff (!rst_n)
    (req_i.rd && req_i.addr == ADDR_A_DATA && !readback_on) |=> (rdata_o & $past(a_func_ff)) == ZERO_BYTE)
    else $error("analogue pin read not zero");
  a_unmapped_read: assert property (@(posedge clock_i) disable iff (!rst_n)
    (req_i.rd && req_i.addr > ADDR_SLEEP) |=> rdata_o == ZERO_BYTE)
    else $error("unmapped read not zero");
  a_rdata_idle: assert property (@(posedge clock_i) disable iff (!rst_n)
    !req_i.rd |=> rdata_o == ZERO_BYTE)
    else $error("read data without read");

  // Analogue path switches.
  a_analog_off: assert property (@(posedge clock_i) disable iff (!rst_n)
    !readback_on |-> (analog_input_channels_o & ~func_all) == 16'h0000)
    else $error("path on unselected");
  a_analog_norm: assert property (@(posedge clock_i) disable iff (!rst_n)
    (!readback_on && func_all[adc_sel_ff]) |-> analog_input_channels_o[adc_sel_ff])
    else $error("selected path off");
  a_analog_force: assert property (@(posedge clock_i) disable iff (!rst_n)
    readback_on |-> analog_input_channels_o == (16'h0001 << adc_sel_ff))
    else $error("forced path wrong");

  // Reset defaults, direction, latch hold and key echo.
  a_reset_high: assert property (@(posedge clock_i)
    $rose(rst_n) |-> a_data_ff == PORT_RESET && a_dir_ff == PORT_RESET && b_data_ff == PORT_RESET &&
    b_dir_ff == PORT_RESET && key_ff == KEY_RESET)
    else $error("reset values wrong");
  a_dir_input: assert property (@(posedge clock_i) disable iff (!rst_n)
    (drive_a_o.out_en_b & ~a_dir_ff & ~a_func_ff) == ZERO_BYTE && (a_dir_ff & ~drive_a_o.out_en_b) == ZERO_BYTE)
    else $error("direction not honoured");
  a_dir_input_b: assert property (@(posedge clock_i) disable iff (!rst_n)
    (drive_b_o.out_en_b & ~b_dir_ff & ~b_func_ff) == ZERO_BYTE && (b_dir_ff & ~drive_b_o.out_en_b) == ZERO_BYTE)
    else $error("direction not honoured on b");
  a_latch_hold: assert property (@(posedge clock_i) disable iff (!rst_n)
    (!wr_adata && !bop_hit_adata) |=> $stable(drive_a_o.out_val))
    else $error("latch moved without write");
  a_key_echo: assert property (@(posedge clock_i) disable iff (!rst_n)
    wr_key ##1 !wr_key ##1 (req_i.rd && req_i.addr == ADDR_KEY) |=> rdata_o == $past(req_i.wdata, 3))
    else $error("key not read back");

  a_bitop_clear: assert property (@(posedge clock_i) disable iff (!rst_n)
    (bop_hit_bdir && !req_i.wdata[BITOP_SET])
    |=> b_dir_ff == ($past(b_dir_ff) & ~(8'h01 << $past(req_i.wdata[BITOP_IDX_HI:BITOP_IDX_LO]))))
    else $error("bit clear lost");
  a_bitop_set: assert property (@(posedge clock_i) disable iff (!rst_n)
    (bop_hit_bdata && req_i.wdata[BITOP_SET]) |=> b_data_ff[$past(req_i.wdata[BITOP_IDX_HI:BITOP_IDX_LO])])
    else $error("bit set lost");

  // Wake-up and its sticky status bit.
  a_wake_fall: assert property (@(posedge clock_i) disable iff (!rst_n)
    (sleep_ff && (a_prev_ff & ~a_s2_ff & a_wake_ff) != ZERO_BYTE) |=> wake_o && !sleep_ff)
    else $error("missed wake");
  a_wake_status: assert property (@(posedge clock_i) disable iff (!rst_n)
    wake_o |-> irq_stat_ff[IRQ_WAKE])
    else $error("wake not recorded");
  a_wake_asleep: assert property (@(posedge clock_i) disable iff (!rst_n)
    !sleep_ff |=> !wake_o)
    else $error("wake while awake");
  a_stat_sticky: assert property (@(posedge clock_i) disable iff (!rst_n)
    (irq_stat_ff[IRQ_WAKE] && !rd_stat) |=> irq_stat_ff[IRQ_WAKE])
    else $error("status bit lost");
  a_stat_clear: assert property (@(posedge clock_i) disable iff (!rst_n)
    (rd_stat && !wake_evt) |=> !irq_stat_ff[IRQ_WAKE])
    else $error("status not cleared by read");
  a_irq_level: assert property (@(posedge clock_i) disable iff (!rst_n)
    (irq_stat_ff[IRQ_WAKE] && irq_mask_ff[IRQ_WAKE]) |-> irq_o)
    else $error("interrupt not raised");

  c_readback_on: cover property (@(posedge clock_i) disable iff (!rst_n) $rose(readback_on));
  c_key_wrong: cover property (@(posedge clock_i) disable iff (!rst_n) wr_key && req_i.wdata != UNLOCK_PATTERN);
  c_wake: cover property (@(posedge clock_i) disable iff (!rst_n) wake_o);
  c_bitop: cover property (@(posedge clock_i) disable iff (!rst_n) bop_hit_bdata);
  c_irq: cover property (@(posedge clock_i) disable iff (!rst_n) irq_o);
endmodule

// [testbench/board_model.sv]
// Board model for the two eight-bit ports: resolves each pin from the block's drive and the board's level.
// Assumes the bench gives the level that the board holds on every pin the block releases.
`timescale 1ns/1ps
module board_model (
  input  wire readback_pkg::pin_drive_t drive_a_i,
  input  wire readback_pkg::pin_drive_t drive_b_i,
  input  wire logic [7:0]               ext_a_i,
  input  wire logic [7:0]               ext_b_i,
  output logic [7:0]                    pin_a_o,
  output logic [7:0]                    pin_b_o
);
  import readback_pkg::*;
  // A released pin shows the board level, so a stale drive value can never pass for a read of the pin.
  assign pin_a_o = (drive_a_i.out_val & ~drive_a_i.out_en_b) | (ext_a_i & drive_a_i.out_en_b);
  assign pin_b_o = (drive_b_i.out_val & ~drive_b_i.out_en_b) | (ext_b_i & drive_b_i.out_en_b);
endmodule

// [testbench/test_port_readback_selftest.sv]
// Self-checking bench for the port read-back self-test block.
// Assumes the board model closes the pin loop and every register is reached over the plain port.
`timescale 1ns/1ps
module test_port_readback_selftest;
  import readback_pkg::*;
  logic       clock_i = 1'b0;
  logic       rst_b_i = 1'b0;
  reg_req_t   req     = '0;
  logic [7:0] ext_a   = 8'hff;
  logic [7:0] ext_b   = 8'h3c;
  logic [7:0] rdata;
  logic [7:0] pin_a;
  logic [7:0] pin_b;
  pin_drive_t drv_a;
  pin_drive_t drv_b;
  logic [15:0] analog;
  logic       flag;
  logic       wake;
  logic       irq;
  logic       seen;
  int         fails       = 0;
  int         comparisons = 0;
  int         cycles      = 0;
  logic [7:0] keys [5]    = '{8'hcb, 8'hc8, 8'h4a, 8'hea, 8'hca};
  always #5 clock_i = ~clock_i;
  port_readback_selftest #(.PORT_W(8)) dut_u (.clock_i(clock_i), .rst_b_i(rst_b_i), .req_i(req),
    .rdata_o(rdata), .pin_a_i(pin_a), .pin_b_i(pin_b), .drive_a_o(drv_a), .drive_b_o(drv_b),
    .analog_input_channels_o(analog), .readback_enable_flag_o(flag), .wake_o(wake), .irq_o(irq));
  board_model board_u (.drive_a_i(drv_a), .drive_b_i(drv_b), .ext_a_i(ext_a), .ext_b_i(ext_b),
    .pin_a_o(pin_a), .pin_b_o(pin_b));
  task automatic end_sim();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    req <= '0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    req <= '0;
    #1;
    chk({8'h00, rdata}, {8'h00, exp});
  endtask
  // Sampling after each edge settles keeps a one-cycle wake pulse from being missed or double counted.
  task automatic wait_wake(input int n);
    seen = 1'b0;
    repeat (n) begin
      @(posedge clock_i);
      #1;
      if (wake === 1'b1) seen = 1'b1;
    end
  endtask
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    repeat (8) @(posedge clock_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    chk(drv_a, {PORT_RESET, PORT_RESET});
    chk({15'h0000, flag}, 16'h0000);
    rd(ADDR_KEY, KEY_RESET);
    rd(ADDR_A_DIR, PORT_RESET);
    rd(ADDR_B_DIR, PORT_RESET);
    rd(ADDR_B_DATA, 8'h3c);
    rd(4'hf, ZERO_BYTE);
    wr(ADDR_A_DIR, 8'h00);
    chk(drv_a, 16'hff00);
    chk({8'h00, pin_a}, 16'h00ff);
    rd(ADDR_A_DATA, 8'hff);
    wr(ADDR_A_DATA, 8'h5a);
    rd(ADDR_A_DATA, 8'h5a);
    @(posedge clock_i) ext_a <= 8'h0f;
    wr(ADDR_A_FUNC, 8'h03);
    chk(drv_a, 16'h5a03);
    rd(ADDR_A_DATA, 8'h58);
    wr(ADDR_ADC_SEL, 8'h01);
    chk(analog, 16'h0002);
    wr(ADDR_ADC_SEL, 8'h02);
    chk(analog, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_KEY, keys[i]);
      chk({15'h0000, flag}, {15'h0000, keys[i] == UNLOCK_PATTERN});
      rd(ADDR_KEY, keys[i]);
    end
    chk(analog, 16'h0004);
    rd(ADDR_A_DATA, 8'h5b);
    rd(ADDR_B_DATA, 8'h3c);
    wr(ADDR_KEY, 8'h00);
    chk(analog, 16'h0000);
    wr(ADDR_BITOP, 8'h83);
    wr(ADDR_BITOP, 8'h74);
    rd(ADDR_B_DIR, 8'h7f);
    chk(drv_b, 16'h3d7f);
    wr(ADDR_A_DIR, 8'hff);
    wr(ADDR_A_WAKE, 8'h08);
    wr(ADDR_SLEEP, 8'h01);
    @(posedge clock_i) ext_a <= 8'h0b;
    wait_wake(8);
    chk({15'h0000, seen}, 16'h0000);
    @(posedge clock_i) ext_a <= 8'h03;
    wait_wake(8);
    chk({15'h0000, seen}, 16'h0001);
    chk({15'h0000, irq}, 16'h0000);
    wr(ADDR_IRQ_MASK, 8'h01);
    chk({15'h0000, irq}, 16'h0001);
    rd(ADDR_IRQ_STAT, 8'h01);
    chk({15'h0000, irq}, 16'h0000);
    rd(ADDR_IRQ_STAT, 8'h00);
    end_sim();
  end
endmodule
